/* byte_mem_dma_pkg.sv */
/*
  Package for the byte-memory DMA engine: register offsets, field layouts,
  reset and boot values, states and the packed carriers of the memory ports.
  Assumes a single 40 MHz clock domain and an AXI4-Lite register bus.
*/
// What this block does
// R01 - Byte memory: 256 pages of 16K bytes
// R02 - Byte data on bus bits 15:8
// R03 - Page on bits 23:16, address 13:0
// R04 - Byte accesses timed by wait-state setting
// R05 - One processor cycle stolen per word
// R06 - Format field selects word size, alignment
// R07 - As many byte accesses as word needs
// R08 - Unused half of 8-bit words zeroed
// R09 - Start addresses from internal, external, page
// R10 - Direction picks byte-to-chip or chip-to-byte
// R11 - Nonzero count write starts the transfer
// R12 - Addressing runs across page boundaries
// R13 - Count decrements; zero raises completion interrupt
// R14 - Software leaves page, address alone during transfer
// R15 - Internal side always on-chip memory
// R16 - Complete word moves in one cycle
// R17 - Processor external accesses take priority
// R18 - Context-reset bit holds, restarts processor
// R19 - Overlay bits pick internal memory block
// R20 - Boot strap starts transfer at reset release
// R21 - Boot presets: zeros, 24-bit, 32, hold
// R22 - Host mode drives only address bit A0
// R23 - Address wraps to zero, page increments
// R24 - Most significant byte first, lowest address
package byte_mem_dma_pkg;

  localparam int PAGE_BITS  = 8;
  localparam int EADDR_BITS = 14;
  localparam int COUNT_BITS = 14;
  localparam int IADDR_BITS = 14;
  localparam int OVL_BITS   = 4;
  localparam int WAIT_BITS  = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_IADDR = 8'h04;
  localparam logic [7:0] OFS_EADDR = 8'h08;
  localparam logic [7:0] OFS_PAGE  = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Control register fields
  localparam int CTRL_FMT_LSB  = 0;
  localparam int CTRL_DIR_BIT  = 2;
  localparam int CTRL_CR_BIT   = 3;
  localparam int CTRL_OVL_LSB  = 4;
  localparam int CTRL_WAIT_LSB = 8;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;

  // Boot preset and reset values
  localparam logic [COUNT_BITS-1:0] BOOT_COUNT = 14'h0020;
  localparam logic [WAIT_BITS-1:0]  RST_WAIT   = 3'h7;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FMT_PM24  = 2'b00,
    FMT_DM16  = 2'b01,
    FMT_DM8HI = 2'b10,
    FMT_DM8LO = 2'b11
  } word_format_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_BYTE  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_WORD  = 3'b100
  } dma_state_t;

  // External byte-memory request
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [13:0] addr;
    logic [7:0]  page;
    logic [7:0]  wdata;
  } bmem_req_t;

  // On-chip memory request
  typedef struct packed {
    logic                  en;
    logic                  wr;
    logic                  pm;
    logic [OVL_BITS-1:0]   ovl;
    logic [IADDR_BITS-1:0] addr;
    logic [23:0]           wdata;
  } imem_req_t;

  localparam int NBYTES_PM = 3;
  localparam int NBYTES_DM = 2;

endpackage

/* byte_mem_dma_wait_timer.sv */
/*
  Wait-state timer: counts out the programmed number of wait cycles of one
  byte access and pulses done on its last cycle.
  Assumes the start pulse comes only while the timer is idle.
*/
`timescale 1ns/1ps
module byte_mem_dma_wait_timer
  import byte_mem_dma_pkg::*;
#(
  parameter int W = WAIT_BITS
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] waits,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= waits;
        run_q <= 1'b1;
      end else if (run_q && cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end else begin
        run_q <= 1'b0;
      end
    end
  end

  // Strobe ends one cycle plus the wait count after start
  assign done = run_q && (cnt_q == '0);
endmodule

/* byte_mem_dma.sv */
/*
  Byte-memory DMA engine: moves 24-, 16- or 8-bit words between an external
  byte-wide memory and on-chip program or data memory, with boot loading.
  Assumes on-chip memory returns read data in the same cycle as en, and that the
  processor flags its own external accesses on cpu_ext_req.
*/
`timescale 1ns/1ps
module byte_mem_dma
  import byte_mem_dma_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Boot strap and memory mode, sampled at reset release
  input  wire logic        boot_byte_mem_dma,
  input  wire logic        host_mode,
  input  wire logic        cpu_ext_req,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External bus: data bits 23:8, address 13:0
  output logic [13:0]      ext_addr,
  output logic [23:8]      ext_data_out,
  output logic [23:16]     ext_data_oe,
  output logic [15:8]      ext_data_oe_byte,
  input  wire logic [15:8] ext_data_in,
  output logic             bmem_sel_n,
  output logic             bmem_rd_n,
  output logic             bmem_wr_n,
  // On-chip memory
  output imem_req_t        imem_req,
  input  wire logic [23:0] imem_rdata,
  // Processor control
  output logic             cpu_steal,
  output logic             cpu_hold,
  output logic             cpu_ctx_reset,
  output logic             dma_done_irq
);

  dma_state_t              st_q;
  word_format_sel_t        fmt_q;
  logic                    dir_q;
  logic                    cr_q;
  logic [OVL_BITS-1:0]     ovl_q;
  logic [WAIT_BITS-1:0]    wait_q;
  logic [IADDR_BITS-1:0]   iaddr_q;
  logic [EADDR_BITS-1:0]   eaddr_q;
  logic [PAGE_BITS-1:0]    page_q;
  logic [COUNT_BITS-1:0]   count_q;
  logic [23:0]             word_q;
  logic [1:0]              bidx_q;
  logic                    boot_pend_q;
  logic                    host_q;
  logic                    done_q;

  // Bytes per word from the format field
  function automatic logic [1:0] nbytes(input word_format_sel_t f);
    case (f)
      FMT_PM24: nbytes = 2'(NBYTES_PM);
      FMT_DM16: nbytes = 2'(NBYTES_DM);
      default:  nbytes = 2'd1;
    endcase
  endfunction

  // Byte lane of word for byte index, most significant first
  function automatic logic [7:0] pick_byte(input word_format_sel_t f, input logic [23:0] w, input logic [1:0] i);
    case (f)
      FMT_PM24:  pick_byte = (i == 2'd0) ? w[23:16] : (i == 2'd1) ? w[15:8] : w[7:0];
      FMT_DM16:  pick_byte = (i == 2'd0) ? w[15:8] : w[7:0];
      FMT_DM8HI: pick_byte = w[15:8];
      default:   pick_byte = w[7:0];
    endcase
  endfunction

  // AXI4-Lite slave
  logic aw_hold_q, w_hold_q;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        wr_fire, busy;
  logic        cnt_wr, eaddr_wr, page_wr;

  assign busy    = (st_q != ST_IDLE);
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign cnt_wr  = wr_fire && aw_q == OFS_COUNT && ws_q[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_q          <= '0;
      wd_q          <= '0;
      ws_q          <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q <= OFS_STAT && aw_q[1:0] == 2'b00) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AXI_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= AXI_OKAY;
        case (s_axi_araddr)
          OFS_CTRL:  s_axi_rdata <= {21'h0, wait_q, ovl_q, cr_q, dir_q, fmt_q};
          OFS_IADDR: s_axi_rdata <= {18'h0, iaddr_q};
          OFS_EADDR: s_axi_rdata <= {18'h0, eaddr_q};
          OFS_PAGE:  s_axi_rdata <= {24'h0, page_q};
          // Count is readable so software can poll progress
          OFS_COUNT: s_axi_rdata <= {18'h0, count_q};
          OFS_STAT:  s_axi_rdata <= {29'h0, cpu_hold, done_q, busy};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Engine
  logic wt_start, wt_done, acc_on;
  logic [1:0] last_idx;
  logic [7:0] rd_byte;

  assign last_idx = nbytes(fmt_q) - 2'd1;
  // R14 register guard
  // Software writes to page and address are ignored while busy
  assign eaddr_wr = wr_fire && aw_q == OFS_EADDR && !busy;
  assign page_wr  = wr_fire && aw_q == OFS_PAGE && !busy;
  // R04 wait state timing
  assign wt_start = ce && st_q == ST_BYTE && !cpu_ext_req;
  // Strobes span the whole access, so zero waits still strobe once
  assign acc_on   = (st_q == ST_BYTE && !cpu_ext_req) || (st_q == ST_WORD && !wt_done);

  byte_mem_dma_wait_timer #(.W(WAIT_BITS)) u_wait (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .start (wt_start),
    .waits (wait_q),
    .done  (wt_done)
  );

  // Strap capture just after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_pend_q <= 1'b1;
      host_q      <= 1'b0;
    end else if (ce && boot_pend_q) begin
      boot_pend_q <= 1'b0;
      host_q      <= host_mode;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q  <= FMT_PM24;
      dir_q  <= 1'b0;
      cr_q   <= 1'b0;
      ovl_q  <= '0;
      wait_q <= RST_WAIT;
    end else if (ce) begin
      if (boot_pend_q && boot_byte_mem_dma) begin
        // R21 boot presets
        fmt_q <= FMT_PM24;
        dir_q <= 1'b0;
        cr_q  <= 1'b1;
      end else if (wr_fire && aw_q == OFS_CTRL && ws_q[0] && !busy) begin
        // R06 format field
        fmt_q <= word_format_sel_t'(wd_q[CTRL_FMT_LSB +: 2]);
        // R10 direction field
        dir_q <= wd_q[CTRL_DIR_BIT];
        cr_q  <= wd_q[CTRL_CR_BIT];
        // R19 overlay select
        ovl_q <= wd_q[CTRL_OVL_LSB +: OVL_BITS];
        if (ws_q[1]) begin
          wait_q <= wd_q[CTRL_WAIT_LSB +: WAIT_BITS];
        end
      end
    end
  end

  // Transfer state machine with address and count registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      iaddr_q <= '0;
      eaddr_q <= '0;
      page_q  <= '0;
      count_q <= '0;
      word_q  <= '0;
      bidx_q  <= '0;
      done_q  <= 1'b0;
    end else if (ce) begin
      if (cnt_wr && !busy) begin
        done_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (boot_pend_q && boot_byte_mem_dma) begin
            // R20 boot start
            iaddr_q <= '0;
            eaddr_q <= '0;
            page_q  <= '0;
            count_q <= BOOT_COUNT;
            bidx_q  <= '0;
            st_q    <= ST_BYTE;
          end else begin
            // R09 start addresses
            if (wr_fire && aw_q == OFS_IADDR && ws_q[0]) begin
              iaddr_q <= wd_q[IADDR_BITS-1:0];
            end
            if (eaddr_wr) begin
              eaddr_q <= wd_q[EADDR_BITS-1:0];
            end
            if (page_wr) begin
              page_q <= wd_q[PAGE_BITS-1:0];
            end
            // R11 nonzero count starts
            if (cnt_wr) begin
              count_q <= wd_q[COUNT_BITS-1:0];
              bidx_q  <= '0;
              if (wd_q[COUNT_BITS-1:0] != '0) begin
                st_q <= dir_q ? ST_FETCH : ST_BYTE;
              end
            end
          end
        end
        ST_FETCH: begin
          st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Read data from on-chip memory returns this cycle
          word_q <= imem_rdata;
          st_q   <= ST_BYTE;
        end
        ST_BYTE: begin
          // R17 processor priority
          if (!cpu_ext_req) begin
            st_q <= ST_WORD;
          end
        end
        ST_WORD: begin
          if (wt_done) begin
            // R23 address wrap and page step
            // R12 page crossing
            {page_q, eaddr_q} <= {page_q, eaddr_q} + 22'd1;
            if (!dir_q) begin
              // R24 most significant first
              word_q <= {word_q[15:0], ext_data_in};
            end
            // R07 byte count per word
            if (bidx_q != last_idx) begin
              bidx_q <= bidx_q + 2'd1;
              st_q   <= ST_BYTE;
            end else begin
              bidx_q  <= '0;
              // R13 count decrement
              count_q <= count_q - 14'd1;
              iaddr_q <= iaddr_q + 14'd1;
              if (count_q == 14'd1) begin
                done_q <= 1'b1;
                st_q   <= ST_IDLE;
              end else begin
                st_q <= dir_q ? ST_FETCH : ST_BYTE;
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Registered outputs
  logic [7:0]  out_byte;
  logic        word_ready;
  logic [23:0] wr_word;

  assign out_byte   = pick_byte(fmt_q, word_q, bidx_q);
  assign rd_byte    = ext_data_in;
  assign word_ready = st_q == ST_WORD && wt_done && bidx_q == last_idx;
  // R08 zero fill of unused half
  always_comb begin
    case (fmt_q)
      FMT_PM24:  wr_word = {word_q[15:0], rd_byte};
      FMT_DM16:  wr_word = {8'h00, word_q[7:0], rd_byte};
      FMT_DM8HI: wr_word = {8'h00, rd_byte, 8'h00};
      default:   wr_word = {16'h0000, rd_byte};
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_addr         <= '0;
      ext_data_out     <= '0;
      ext_data_oe      <= '0;
      ext_data_oe_byte <= '0;
      bmem_sel_n       <= 1'b1;
      bmem_rd_n        <= 1'b1;
      bmem_wr_n        <= 1'b1;
      imem_req         <= '0;
      cpu_steal        <= 1'b0;
      cpu_hold         <= 1'b0;
      cpu_ctx_reset    <= 1'b0;
      dma_done_irq     <= 1'b0;
    end else if (ce) begin
      // R01 R03 22-bit byte address
      // R22 host mode drives only A0
      ext_addr         <= host_q ? {13'h0, eaddr_q[0]} : eaddr_q;
      ext_data_out     <= {page_q, out_byte};
      ext_data_oe      <= (acc_on && !host_q) ? 8'hff : 8'h00;
      // R02 data on bits 15:8
      ext_data_oe_byte <= (acc_on && dir_q) ? 8'hff : 8'h00;
      bmem_sel_n       <= !acc_on;
      bmem_rd_n        <= !(acc_on && !dir_q);
      bmem_wr_n        <= !(acc_on && dir_q);
      // R15 R16 one-cycle on-chip word move
      imem_req.en      <= (word_ready && !dir_q) || (st_q == ST_FETCH);
      imem_req.wr      <= word_ready && !dir_q;
      imem_req.pm      <= (fmt_q == FMT_PM24);
      imem_req.ovl     <= ovl_q;
      imem_req.addr    <= iaddr_q;
      imem_req.wdata   <= wr_word;
      // R05 one stolen cycle per word
      cpu_steal        <= (word_ready && !dir_q) || (st_q == ST_FETCH);
      // R18 context reset hold
      cpu_hold         <= (busy || (boot_pend_q && boot_byte_mem_dma)) && (cr_q || (boot_pend_q && boot_byte_mem_dma))
                          && !(word_ready && count_q == 14'd1);
      cpu_ctx_reset    <= cr_q && word_ready && count_q == 14'd1;
      // R13 completion interrupt
      dma_done_irq     <= word_ready && count_q == 14'd1;
    end
  end
endmodule

/* byte_mem_dma_assertions.sv */
/*
  Port-level checker for the byte-memory DMA engine, bound to its top module.
  Assumes the mode straps stay steady while reset is released.
*/
`timescale 1ns/1ps
module byte_mem_dma_checker
  import byte_mem_dma_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire logic         ce,
  input wire logic         host_mode,
  input wire logic         cpu_ext_req,
  input wire logic [13:0]  ext_addr,
  input wire logic [23:8]  ext_data_out,
  input wire logic [23:16] ext_data_oe,
  input wire logic [15:8]  ext_data_oe_byte,
  input wire logic         bmem_sel_n,
  input wire logic         bmem_rd_n,
  input wire logic         bmem_wr_n,
  input wire imem_req_t    imem_req,
  input wire logic         cpu_steal,
  input wire logic         cpu_hold,
  input wire logic         cpu_ctx_reset,
  input wire logic         dma_done_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [21:0] last_q;
  logic        have_q;
  wire  [21:0] ba = {ext_data_out[23:16], ext_addr};
  // Byte address of the previous access within one transfer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      have_q <= 1'b0;
      last_q <= 22'h0;
    end else if (dma_done_irq) begin
      have_q <= 1'b0;
    end else if ($fell(bmem_sel_n)) begin
      have_q <= 1'b1;
      last_q <= ba;
    end
  end
  property p_rd_only;
    !bmem_rd_n |-> bmem_wr_n && ext_data_oe_byte == 8'h00;
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read strobe with write or data drive");
  property p_wr_byte;
    !bmem_wr_n |-> !bmem_sel_n && ext_data_oe_byte == 8'hff;
  endproperty
  a_wr_byte: assert property (p_wr_byte) else $error("write byte not driven");
  property p_page_drive;
    !bmem_sel_n && !host_mode |-> ext_data_oe == 8'hff;
  endproperty
  a_page_drive: assert property (p_page_drive) else $error("page not driven");
  property p_host_a0;
    host_mode && !bmem_sel_n |-> ext_addr[13:1] == 13'h0 && ext_data_oe == 8'h00;
  endproperty
  a_host_a0: assert property (p_host_a0) else $error("host mode drives more than A0");
  property p_addr_step;
    $fell(bmem_sel_n) && have_q && !host_mode |-> ba == last_q + 22'h1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("byte address not sequential");
  property p_cpu_prio;
    ce && cpu_ext_req && bmem_sel_n |=> bmem_sel_n;
  endproperty
  a_cpu_prio: assert property (p_cpu_prio) else $error("byte access during processor access");
  property p_word_pulse;
    imem_req.en |=> !imem_req.en;
  endproperty
  a_word_pulse: assert property (p_word_pulse) else $error("word move longer than one cycle");
  property p_steal;
    imem_req.en |-> ##[0:1] cpu_steal;
  endproperty
  a_steal: assert property (p_steal) else $error("word moved without stolen cycle");
  property p_done_pulse;
    dma_done_irq |=> !dma_done_irq [*2];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("completion not a single pulse");
  property p_ctx;
    cpu_ctx_reset |-> $past(cpu_hold) && !$past(cpu_ctx_reset);
  endproperty
  a_ctx: assert property (p_ctx) else $error("context reset without hold");
  c_hold: cover property ($rose(cpu_hold));
  c_ctx: cover property (cpu_ctx_reset);
  c_host: cover property (host_mode && !bmem_sel_n);
endmodule

bind byte_mem_dma byte_mem_dma_checker u_chk (.*);

/* byte_mem_model.sv */
/*
  Behavioural byte-wide memory on the external bus, 22-bit byte address.
  Assumes strobes are held for the whole access; unwritten bytes read a pattern.
*/
`timescale 1ns/1ps
module byte_mem_model (
  input  wire logic        mclk,
  input  wire logic [13:0] ext_addr,
  input  wire logic [23:8] ext_data_out,
  input  wire logic        bmem_sel_n,
  input  wire logic        bmem_rd_n,
  input  wire logic        bmem_wr_n,
  output logic      [15:8] ext_data_in
);
  logic [7:0]  mem [logic [21:0]];
  logic [7:0]  last_q = 8'h00;
  wire  [21:0] ba = {ext_data_out[23:16], ext_addr};
  function automatic logic [7:0] fetch(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[21:14];
  endfunction
  // read byte, inverted last value when released
  always_comb ext_data_in = (!bmem_sel_n && !bmem_rd_n) ? fetch(ba) : ~last_q;
  always @(ext_data_in) if (!bmem_sel_n && !bmem_rd_n) last_q = ext_data_in;
  always @(posedge mclk) if (!bmem_sel_n && !bmem_wr_n) mem[ba] = ext_data_out[15:8];
endmodule

/* byte_mem_dma_tb.sv */
/*
  Self-checking bench for the byte-memory DMA engine.
  Assumes the byte memory model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module byte_mem_dma_tb;
  import byte_mem_dma_pkg::*;
  logic         mclk = 1'b0, rst_n = 1'b0, boot = 1'b0, host = 1'b0, ext_req = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]  wdata = 32'h0000_0000;
  logic         awready, wready, bvalid, arready, rvalid, sel_n, rd_n, wr_n, steal, hold, ctx, irq;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata;
  logic [13:0]  ext_addr;
  logic [23:8]  ext_out;
  logic [23:16] ext_oe;
  logic [15:8]  oe_byte, data_in;
  imem_req_t    req;
  wire  [23:0]  imem_rdata = {8'hc3, 2'b00, req.addr};
  imem_req_t    wq[$];
  int           num_errors = 0, samples_checked = 0, irq_cnt, ctx_cnt, hold_cnt, cur = 0, last_len = 0, l0;
  always #12.5 mclk = ~mclk;
  byte_mem_dma DUT (.mclk, .rst_n, .ce(1'b1), .boot_byte_mem_dma(boot), .host_mode(host), .cpu_ext_req(ext_req),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_addr, .ext_data_out(ext_out), .ext_data_oe(ext_oe), .ext_data_oe_byte(oe_byte),
    .ext_data_in(data_in), .bmem_sel_n(sel_n), .bmem_rd_n(rd_n), .bmem_wr_n(wr_n), .imem_req(req), .imem_rdata,
    .cpu_steal(steal), .cpu_hold(hold), .cpu_ctx_reset(ctx), .dma_done_irq(irq));
  byte_mem_model mdl (.mclk, .ext_addr, .ext_data_out(ext_out), .bmem_sel_n(sel_n), .bmem_rd_n(rd_n),
    .bmem_wr_n(wr_n), .ext_data_in(data_in));
  // On-chip memory side and event counters
  always @(posedge mclk) begin
    if (req.en && req.wr) wq.push_back(req);
    if (irq) irq_cnt++;
    if (ctx) ctx_cnt++;
    if (hold) hold_cnt++;
    if (!rd_n) cur++;
    else if (cur != 0) begin
      last_len = cur;
      cur = 0;
    end
  end
  function automatic logic [7:0] bexp(input logic [21:0] a);
    return a[7:0] ^ a[21:14];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = AXI_OKAY);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = AXI_OKAY);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(s, e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  task automatic do_reset(input logic b, input logic h);
    @(posedge mclk);
    rst_n <= 1'b0;
    boot <= b;
    host <= h;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wq.delete();
    irq_cnt = 0;
    ctx_cnt = 0;
    hold_cnt = 0;
  endtask
  // Checks moved words
  task automatic chk_mem(input logic [1:0] f, input int cnt, input logic [13:0] ea, input logic [7:0] pg,
                         input logic [13:0] ia, input bit d);
    int nb, sh;
    logic [21:0] ba;
    logic [23:0] w, m;
    nb = (f == FMT_PM24) ? 3 : (f == FMT_DM16) ? 2 : 1;
    m = (nb == 3) ? 24'hff_ffff : 24'h00_ffff;
    ba = {pg, ea};
    if (!d) chk("words", cnt, wq.size());
    for (int i = 0; i < cnt; i++) begin
      w = d ? {8'hc3, 2'b00, ia + 14'(i)} : 24'h00_0000;
      for (int k = 0; k < nb; k++) begin
        sh = (nb == 1) ? ((f == FMT_DM8HI) ? 8 : 0) : 8 * (nb - 1 - k);
        if (d) chk("byte out", 32'(w[sh +: 8]), 32'(mdl.mem[ba]));
        else w[sh +: 8] = bexp(ba);
        ba = ba + 22'h1;
      end
      if (!d && i < wq.size()) begin
        if (!host) chk("word in", 32'(w & m), 32'(wq[i].wdata & m));
        chk("word place", {f == FMT_PM24, ia[3:0], ia + 14'(i)}, {wq[i].pm, wq[i].ovl, wq[i].addr});
      end
    end
  endtask
  task automatic t_regs();
    rchk("ctrl", OFS_CTRL, 32'h0000_0700);
    rchk("count", OFS_COUNT, 32'h0000_0000);
    axw(OFS_PAGE, 32'h0000_005a);
    rchk("page", OFS_PAGE, 32'h0000_005a);
    axw(OFS_EADDR, 32'hffff_ffff);
    rchk("eaddr", OFS_EADDR, 32'h0000_3fff);
    rchk("unmapped", 8'h18, 32'h0000_0000, AXI_SLVERR);
    axw(8'h05, 32'h0000_0000, AXI_SLVERR);
    $display("register test done");
  endtask
  task automatic t_xfer(input logic [1:0] f, input int cnt, input logic [13:0] ea, input logic [7:0] pg,
                        input logic [13:0] ia, input logic [2:0] wt, input bit d, input bit poke);
    int n;
    n = irq_cnt;
    wq.delete();
    axw(OFS_CTRL, {21'h0, wt, ia[3:0], 1'b0, d, f});
    axw(OFS_IADDR, 32'(ia));
    axw(OFS_EADDR, 32'(ea));
    axw(OFS_PAGE, 32'(pg));
    axw(OFS_COUNT, cnt);
    if (poke) begin
      rchk("status busy", OFS_STAT, 32'h0000_0001);
      axw(OFS_PAGE, 32'h0000_0077);
      axw(OFS_COUNT, 32'h0000_0009);
      ext_req <= 1'b1;
      repeat (20) @(posedge mclk);
      ext_req <= 1'b0;
    end
    while (irq_cnt == n) @(posedge mclk);
    repeat (3) @(posedge mclk);
    chk("irq count", n + 1, irq_cnt);
    rchk("count", OFS_COUNT, 32'h0000_0000);
    rchk("status", OFS_STAT, 32'h0000_0002);
    chk("hold cycles", 0, hold_cnt);
    chk_mem(f, cnt, ea, pg, ia, d);
    $display("transfer done format %0d dir %0d", f, d);
  endtask
  task automatic t_boot();
    do_reset(1'b1, 1'b0);
    while (ctx_cnt == 0) @(posedge mclk);
    repeat (3) @(posedge mclk);
    chk("held", 1, hold_cnt != 0);
    chk("ctx resets", 1, ctx_cnt);
    chk("hold now", 0, 32'(hold));
    chk_mem(FMT_PM24, 32, 14'h0000, 8'h00, 14'h0000, 1'b0);
    $display("boot test done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  initial begin
    do_reset(1'b0, 1'b0);
    t_regs();
    t_xfer(FMT_PM24, 2, 14'h3fff, 8'h01, 14'h0013, 3'd0, 1'b0, 1'b0);
    l0 = last_len;
    for (int f = 1; f < 4; f++) t_xfer(2'(f), 2, 14'h0100, 8'h02, 14'h0200, 3'd7, 1'b0, 1'b0);
    chk("access length", l0 + 7, last_len);
    t_xfer(FMT_DM16, 2, 14'h0020, 8'h03, 14'h0040, 3'd1, 1'b1, 1'b0);
    t_xfer(FMT_PM24, 4, 14'h0500, 8'h04, 14'h0100, 3'd7, 1'b0, 1'b1);
    t_boot();
    do_reset(1'b0, 1'b1);
    t_xfer(FMT_DM8LO, 2, 14'h0003, 8'h05, 14'h0300, 3'd0, 1'b0, 1'b0);
    conclude();
  end
endmodule
